// [spims_port.v]
// Purpose: Byte-wide serial peripheral port, master or slave
// Assumes: One clock ref_clk, synchronous active-high reset srst
// Notes: Pins are split into in, out and active-low output enable
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "spims_defs.vh"
module spims_port (
    input wire ref_clk,
    input wire srst,
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire global_irq_enable,
    input wire irq_ack,
    output wire transfer_irq,
    input wire ss_is_input,
    input wire ss_n_in,
    input wire sck_in,
    output wire sck_out,
    output wire sck_oe_n,
    input wire mosi_in,
    output wire mosi_out,
    output wire mosi_oe_n,
    input wire miso_in,
    output wire miso_out,
    output wire miso_oe_n
);

    // Half period of the master clock in system cycles
    function [6:0] half_period;
        input dbl;
        input [1:0] rate;
        begin
            case ({dbl, rate})
                3'h0: half_period = `SPIMS_HALF_DIV4;
                3'h1: half_period = `SPIMS_HALF_DIV16;
                3'h2: half_period = `SPIMS_HALF_DIV64;
                3'h3: half_period = `SPIMS_HALF_DIV128;
                3'h4: half_period = `SPIMS_HALF_DIV2;
                3'h5: half_period = `SPIMS_HALF_DIV8;
                3'h6: half_period = `SPIMS_HALF_DIV32;
                default: half_period = `SPIMS_HALF_DIV64;
            endcase
        end
    endfunction

    // Shift one received bit in, honouring the bit order
    function [7:0] shift_in;
        input [7:0] cur;
        input lsb;
        input din;
        begin
            if (lsb)
                shift_in = {din, cur[7:1]};
            else
                shift_in = {cur[6:0], din};
        end
    endfunction

    reg [7:0] ctl_q;
    reg dbl_q;
    reg done_q;
    reg write_collision_flag_q;
    reg arm_done_q;
    reg arm_write_collision_flag_q;
    reg [7:0] tx_q;
    reg [7:0] hold_q;
    reg [7:0] rxs_q;
    reg [7:0] rxbuf_q;
    reg [2:0] bit_cnt_q;
    reg busy_q;
    reg sck_q;
    reg [6:0] div_q;
    reg slv_xfer_q;
    reg slv_lvl_q;
    reg [1:0] ss_sync_q;
    reg [1:0] sck_sync_q;
    reg [1:0] mosi_sync_q;
    reg [1:0] miso_sync_q;

    // Pins from outside pass two flops before any logic looks at them
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            ss_sync_q <= 2'h3;
            sck_sync_q <= 2'h0;
            mosi_sync_q <= 2'h0;
            miso_sync_q <= 2'h0;
        end
        else
        begin
            ss_sync_q <= {ss_sync_q[0], ss_n_in};
            sck_sync_q <= {sck_sync_q[0], sck_in};
            mosi_sync_q <= {mosi_sync_q[0], mosi_in};
            miso_sync_q <= {miso_sync_q[0], miso_in};
        end
    end

    wire ss_n_s = ss_sync_q[1];
    wire sck_s = sck_sync_q[1];
    wire mosi_s = mosi_sync_q[1];
    wire miso_s = miso_sync_q[1];

    wire en = ctl_q[`SPIMS_CTL_ENABLE];
    wire master = ctl_q[`SPIMS_CTL_MASTER];
    wire lsb = ctl_q[`SPIMS_CTL_LSB_FIRST];
    wire clock_polarity = ctl_q[`SPIMS_CTL_CLOCK_POLARITY];
    wire clock_phase = ctl_q[`SPIMS_CTL_CLOCK_PHASE];
    wire [1:0] rate = {ctl_q[`SPIMS_CTL_RATE_HI], ctl_q[`SPIMS_CTL_RATE_LO]};

    // Register port decodes
    wire wr_ctl = reg_wr && (reg_addr == `SPIMS_REG_CONTROL);
    wire wr_sts = reg_wr && (reg_addr == `SPIMS_REG_STATUS);
    wire wr_dat = reg_wr && (reg_addr == `SPIMS_REG_DATA);
    wire rd_sts = reg_rd && (reg_addr == `SPIMS_REG_STATUS);
    wire dat_acc = (reg_wr || reg_rd) && (reg_addr == `SPIMS_REG_DATA);

    // Slave select as an input pulled low while master: demote
    wire mode_fault = en && master && ss_is_input && !ss_n_s;

    // Slave is live only while enabled, slave and selected
    wire slv_act = en && !master && !ss_n_s;
    wire slv_lvl = sck_s ^ clock_polarity;
    wire slv_lead = slv_act && slv_lvl && !slv_lvl_q;
    wire slv_trail = slv_act && !slv_lvl && slv_lvl_q;

    // Master edge generator; rate bits only used here
    wire [6:0] half = half_period(dbl_q, rate);
    wire m_tick = busy_q && (div_q == half - 7'h01);
    wire m_lead = m_tick && !sck_q;
    wire m_trail = m_tick && sck_q;

    wire lead = master ? m_lead : slv_lead;
    wire trail = master ? m_trail : slv_trail;
    wire din = master ? miso_s : mosi_s;

    // Phase bit picks which edge samples; the other sets up
    wire sample = clock_phase ? trail : lead;
    wire setup = clock_phase ? (lead && (bit_cnt_q != 3'h0)) : trail;
    wire last = trail && (bit_cnt_q == `SPIMS_LAST_BIT);
    wire xfer = busy_q || slv_xfer_q;
    wire [7:0] rx_next = shift_in(rxs_q, lsb, din);
    wire start = wr_dat && !xfer;
    wire collide = wr_dat && xfer;

    // Control register; hardware demotion wins over a write
    always @(posedge ref_clk)
    begin
        if (srst)
            ctl_q <= `SPIMS_CONTROL_RESET;
        else if (mode_fault)
            ctl_q[`SPIMS_CTL_MASTER] <= 1'b0;
        else if (wr_ctl)
            ctl_q <= reg_wdata;
    end

    // Double-rate bit is the only writable status bit
    always @(posedge ref_clk)
    begin
        if (srst)
            dbl_q <= 1'b0;
        else if (wr_sts)
            dbl_q <= reg_wdata[`SPIMS_STS_DOUBLE];
    end

    // A status read arms the clear; a later data access fires it
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            arm_done_q <= 1'b0;
            arm_write_collision_flag_q <= 1'b0;
        end
        else if (rd_sts)
        begin
            arm_done_q <= done_q || write_collision_flag_q;
            arm_write_collision_flag_q <= write_collision_flag_q;
        end
        else if (dat_acc)
        begin
            arm_done_q <= 1'b0;
            arm_write_collision_flag_q <= 1'b0;
        end
    end

    // Done flag: set wins over either clear path
    always @(posedge ref_clk)
    begin
        if (srst)
            done_q <= 1'b0;
        else if (last || mode_fault)
            done_q <= 1'b1;
        else if (irq_ack || (dat_acc && arm_done_q))
            done_q <= 1'b0;
    end

    // Collision flag: set wins over the clear
    always @(posedge ref_clk)
    begin
        if (srst)
            write_collision_flag_q <= 1'b0;
        else if (collide)
            write_collision_flag_q <= 1'b1;
        else if (dat_acc && arm_write_collision_flag_q)
            write_collision_flag_q <= 1'b0;
    end

    // Master clock divider and idle-level clock phase
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            busy_q <= 1'b0;
            sck_q <= 1'b0;
            div_q <= 7'h00;
        end
        else if (!en || !master || mode_fault)
        begin
            busy_q <= 1'b0;
            sck_q <= 1'b0;
            div_q <= 7'h00;
        end
        else if (start)
        begin
            busy_q <= 1'b1;
            sck_q <= 1'b0;
            div_q <= 7'h00;
        end
        else if (busy_q)
        begin
            if (m_tick)
            begin
                div_q <= 7'h00;
                sck_q <= !sck_q;
                if (last)
                    busy_q <= 1'b0;
            end
            else
            begin
                div_q <= div_q + 7'h01;
            end
        end
    end

    // Slave clock history and in-progress mark
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            slv_lvl_q <= 1'b0;
            slv_xfer_q <= 1'b0;
        end
        else
        begin
            slv_lvl_q <= slv_lvl;
            if (!slv_act)
                slv_xfer_q <= 1'b0;
            else if (last)
                slv_xfer_q <= 1'b0;
            else if (slv_lead)
                slv_xfer_q <= 1'b1;
        end
    end

    // Bit counter restarts per byte and on every deselect
    always @(posedge ref_clk)
    begin
        if (srst)
            bit_cnt_q <= 3'h0;
        else if (!en || mode_fault || start || (!master && ss_n_s))
            bit_cnt_q <= 3'h0;
        else if (trail)
            bit_cnt_q <= bit_cnt_q + 3'h1;
    end

    // Transmit shifter: single buffered, reloaded on deselect
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            tx_q <= `SPIMS_DATA_RESET;
            hold_q <= `SPIMS_DATA_RESET;
        end
        else if (start)
        begin
            tx_q <= reg_wdata;
            hold_q <= reg_wdata;
        end
        else if (!master && ss_n_s)
            tx_q <= hold_q;
        else if (setup)
        begin
            if (lsb)
                tx_q <= {1'b0, tx_q[7:1]};
            else
                tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // Receive shifter feeds a buffer that lasts a full byte
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            rxs_q <= `SPIMS_DATA_RESET;
            rxbuf_q <= `SPIMS_DATA_RESET;
        end
        else
        begin
            if ((!master && ss_n_s) || start)
                rxs_q <= `SPIMS_DATA_RESET;
            else if (sample)
                rxs_q <= rx_next;
            // Last sample precedes the final trailing edge in phase 0
            if (last)
                rxbuf_q <= clock_phase ? rx_next : rxs_q;
        end
    end

    // Read data appear one cycle after the strobe; unmapped reads zero
    always @(posedge ref_clk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `SPIMS_REG_CONTROL: reg_rdata <= ctl_q;
                `SPIMS_REG_STATUS: reg_rdata <= {done_q, write_collision_flag_q, 5'h00, dbl_q};
                `SPIMS_REG_DATA: reg_rdata <= rxbuf_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // Interrupt request is a plain gate of flag and enables
    assign transfer_irq = done_q && ctl_q[`SPIMS_CTL_IRQ_EN] && global_irq_enable;

    // Pins: output bit is whichever end of the shifter leads
    wire out_bit = lsb ? tx_q[0] : tx_q[7];
    assign sck_out = sck_q ^ clock_polarity;
    assign sck_oe_n = !(en && master);
    assign mosi_out = out_bit;
    assign mosi_oe_n = !(en && master);
    assign miso_out = out_bit;
    assign miso_oe_n = !slv_act;

endmodule // spims_port
`default_nettype wire

// [spims_defs.vh]
// Purpose: Shared constants for the byte-wide serial port
// Assumes: Included by its bare name from the design file
// Notes: Register indices sit on a two-bit register address
// Function
// - Four modes from polarity and phase bits
// - Drive and sample on opposite clock edges
// - Interrupt when enable, flag and global set
// - Serial enable gates every serial operation
// - Bit order bit selects LSB first
// - Master select, demoted by low slave select
// - Polarity bit sets idle clock level
// - Phase bit picks sample or setup edge
// - Master clock divided by rate bits
// - Rate bits ignored in slave mode
// - Done flag set on byte completion
// - Done cleared by vector or status-data
// - Collision flag on write during transfer
// - Status bits five to one read zero
// - Double rate bit halves master divisor
// - Data write loads byte, starts transfer
// - Data read returns receive buffer
// - Master stops clock after eight bits
// - Single buffered send, double buffered receive
// - Deselected slave tri-states and ignores clock
// - Slave deselect resets send/receive logic
`ifndef SPIMS_DEFS_VH
`define SPIMS_DEFS_VH
`define SPIMS_REG_CONTROL 2'h0
`define SPIMS_REG_STATUS 2'h1
`define SPIMS_REG_DATA 2'h2
`define SPIMS_CTL_IRQ_EN 7
`define SPIMS_CTL_ENABLE 6
`define SPIMS_CTL_LSB_FIRST 5
`define SPIMS_CTL_MASTER 4
`define SPIMS_CTL_CLOCK_POLARITY 3
`define SPIMS_CTL_CLOCK_PHASE 2
`define SPIMS_CTL_RATE_HI 1
`define SPIMS_CTL_RATE_LO 0
`define SPIMS_STS_DONE 7
`define SPIMS_STS_WRITE_COLLISION_FLAG 6
`define SPIMS_STS_DOUBLE 0
`define SPIMS_CONTROL_RESET 8'h00
`define SPIMS_DATA_RESET 8'h00
`define SPIMS_HALF_DIV4 7'h02
`define SPIMS_HALF_DIV16 7'h08
`define SPIMS_HALF_DIV64 7'h20
`define SPIMS_HALF_DIV128 7'h40
`define SPIMS_HALF_DIV2 7'h01
`define SPIMS_HALF_DIV8 7'h04
`define SPIMS_HALF_DIV32 7'h10
`define SPIMS_LAST_BIT 3'h7
`endif

// [spims_port_sva.sv]
// Purpose: Port-level checks for the serial port
// Assumes: One clock, reset high; control byte mirrored from bus writes
// Notes: Fault demotion of the master bit is not mirrored
`timescale 1ns/100ps
`default_nettype none
module spims_port_sva (
    input wire ref_clk,
    input wire srst,
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire global_irq_enable,
    input wire irq_ack,
    input wire transfer_irq,
    input wire ss_is_input,
    input wire ss_n_in,
    input wire sck_out,
    input wire sck_oe_n,
    input wire mosi_oe_n,
    input wire miso_oe_n
);
default clocking @(posedge ref_clk); endclocking
default disable iff (srst);
logic [7:0] ctl_q;
// Mirror of the control byte as software last wrote it
always @(posedge ref_clk)
    if (srst)
        ctl_q <= 8'h00;
    else if (reg_wr && reg_addr == 2'h0)
        ctl_q <= reg_wdata;
sequence sts_rd;
    reg_rd && reg_addr == 2'h1;
endsequence
sequence ctl_rd;
    reg_rd && reg_addr == 2'h0;
endsequence
// Read slot and register contents
rsvd_zero_a: assert property (sts_rd |=> reg_rdata[5:1] == 5'h00)
    else $error("reserved status bits set");
rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its slot");
ctl_back_a: assert property (ctl_rd |=>
    (reg_rdata & 8'hef) == ($past(ctl_q) & 8'hef)) else $error("control readback wrong");
// Interrupt request gating
irq_gate_a: assert property (!global_irq_enable || !ctl_q[7] |-> !transfer_irq)
    else $error("interrupt while gated");
ack_clear_a: assert property (irq_ack && transfer_irq |=> !transfer_irq)
    else $error("vector did not clear done");
// Pin drivers; a cycle of slack since enables may be registered
off_quiet_a: assert property (!ctl_q[6] && !$past(ctl_q[6]) |->
    sck_oe_n && mosi_oe_n && miso_oe_n) else $error("pins driven while disabled");
slave_sck_a: assert property (!ctl_q[4] && !$past(ctl_q[4]) |->
    sck_oe_n && mosi_oe_n) else $error("slave drives clock");
desel_quiet_a: assert property (ss_n_in [*4] |-> miso_oe_n)
    else $error("deselected slave drives data");
mode_fault_a: assert property ((ss_is_input && !ss_n_in) [*5] |-> sck_oe_n)
    else $error("master kept after select low");
idle_level_a: assert property ($rose(transfer_irq) && $stable(ctl_q) &&
    $stable(global_irq_enable) && !sck_oe_n |-> sck_out == ctl_q[3])
    else $error("clock not idle after byte");
endmodule // spims_port_sva
bind spims_port spims_port_sva i_spims_port_sva (
    .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .global_irq_enable, .irq_ack, .transfer_irq, .ss_is_input, .ss_n_in,
    .sck_out, .sck_oe_n, .mosi_oe_n, .miso_oe_n
);
`default_nettype wire

// [spims_peer.sv]
// Purpose: Behavioural far-side slave for master transfers
// Assumes: Sends its byte MSB first, selected by the bench
// Notes: Released data line shows the inverse of its shifter's top bit
`timescale 1ns/100ps
`default_nettype none
module spims_peer (
    input wire logic sel_n,
    input wire logic sck,
    input wire logic clock_phase,
    input wire logic mosi,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
int n = 0;
logic [7:0] sh = 8'h00;
// Frame start reloads the byte and realigns the edge count
always @(negedge sel_n)
begin
    n = 0;
    sh = tx;
end
// Sample on one edge, set up the next bit on the other
always @(sck)
    if (!sel_n)
    begin
        if (n % 2 == clock_phase)
            rx = {rx[6:0], mosi};
        else if (n > 0)
            sh = sh << 1;
        n++;
    end
assign miso = sh[7] ^ sel_n;
endmodule // spims_peer
`default_nettype wire

// [spi_master_slave_port_bench.sv]
// Purpose: Self-checking bench for the serial port
// Assumes: 25 MHz clock, peer slave on the master link
// Notes: Received byte compared only at half periods of 4 cycles and up; peer byte at every rate
`timescale 1ns/100ps
`default_nettype none
module spi_master_slave_port_bench;
logic ref_clk, srst, reg_wr, reg_rd, global_irq_enable, irq_ack, ss_is_input, ss_n_in;
logic p_sel_n, p_clock_phase, s, b_sck, b_mosi;
logic [1:0] reg_addr, m;
logic [2:0] k;
logic [7:0] reg_wdata, p_tx, tx, e, rd_v;
wire [7:0] reg_rdata, p_rx;
wire sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, transfer_irq, p_miso;
// Bench acts as the far master whenever the port leaves clock or data released
wire sck_w = sck_oe_n ? b_sck : sck_out;
wire mosi_w = mosi_oe_n ? b_mosi : mosi_out;
wire miso_w = miso_oe_n ? p_miso : miso_out;
int n_errors, compares, n, tg, i;
int dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
spims_port i_spims_port (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .global_irq_enable, .irq_ack, .transfer_irq, .ss_is_input, .ss_n_in,
    .sck_in(sck_w), .sck_out, .sck_oe_n, .mosi_in(mosi_w), .mosi_out, .mosi_oe_n,
    .miso_in(miso_w), .miso_out, .miso_oe_n);
spims_peer i_spims_peer (.sel_n(p_sel_n), .sck(sck_w), .clock_phase(p_clock_phase), .mosi(mosi_w),
    .tx(p_tx), .miso(p_miso), .rx(p_rx));
task chk(input [7:0] seen, input [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
        n_errors++;
        $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
endtask
task wr(input [1:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
endtask
// Read data stands only in the cycle after the strobe
task rd(input [1:0] a, output [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
endtask
task stop_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
initial
begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
end
// Watchdog well beyond the longest run of transfers
initial
begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    stop_test;
end
initial
begin
    {reg_wr, reg_rd, irq_ack, ss_is_input, p_clock_phase, b_sck, b_mosi, reg_addr, reg_wdata} = 0;
    {srst, ss_n_in, p_sel_n, global_irq_enable} = 4'hf;
    {n_errors, compares, p_tx} = 0;
    void'($urandom(55));
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
        rd(i[1:0], rd_v);
        chk(rd_v, 8'h00, "reset read");
    end
    // Every rate, every mode, both orders; odd passes collide
    for (i = 0; i < 8; i++)
    begin
        k = i[2:0];
        m = k[1:0] + {1'b0, k[2]};
        wr(1, {7'h00, k[2]});
        wr(0, {2'b11, k[0], 1'b1, m, k[1:0]});
        p_clock_phase = m[0];
        p_tx = $urandom;
        tx = $urandom;
        // Let a polarity change settle before the peer is selected
        @(posedge ref_clk);
        p_sel_n <= 1'b0;
        wr(2, tx);
        n = 0;
        tg = 0;
        s = m[1];
        while (transfer_irq !== 1'b1 && n < 1100)
        begin
            @(posedge ref_clk);
            reg_wr <= (n == 8 && k[0]);
            #1 n++;
            tg += (sck_out !== s);
            s = sck_out;
        end
        chk(n == 8 * dv[i] || n == 8 * dv[i] + 1, 1, "sck rate");
        chk(tg, 16, "sck edges");
        chk(sck_out, m[1], "sck idle");
        if (k == 2)
        begin
            @(posedge ref_clk) irq_ack <= 1'b1;
            @(posedge ref_clk) irq_ack <= 1'b0;
        end
        rd(1, rd_v);
        chk(rd_v, {k != 2, k[0], 5'h00, k[2]}, "status");
        rd(2, rd_v);
        e = k[0] ? {<<{p_tx}} : p_tx;
        if (dv[i] > 4)
            chk(rd_v, e, "rx byte");
        e = k[0] ? {<<{tx}} : tx;
        chk(p_rx, e, "peer rx");
        rd(1, rd_v);
        chk(rd_v, {7'h00, k[2]}, "flags clear");
        p_sel_n <= 1'b1;
    end
    // Slave byte in mode 0; bench clock kept at an eighth of the system rate
    wr(0, 8'h40);
    tx = $urandom;
    e = $urandom;
    wr(2, tx);
    ss_n_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(miso_oe_n, 0, "slave drives data");
    for (i = 7; i >= 0; i--)
    begin
        b_mosi <= e[i];
        repeat (4) @(posedge ref_clk);
        rd_v[i] = miso_w;
        b_sck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        b_sck <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    chk(rd_v, tx, "slave tx");
    rd(1, rd_v);
    chk(rd_v, 8'h81, "slave done");
    rd(2, rd_v);
    chk(rd_v, e, "slave rx");
    ss_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(miso_oe_n, 1, "slave released");
    // Low slave select demotes a master
    wr(0, 8'hd0);
    ss_is_input <= 1'b1;
    ss_n_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(0, rd_v);
    chk(rd_v, 8'hc0, "demoted");
    rd(1, rd_v);
    chk(rd_v, 8'h81, "fault done");
    global_irq_enable <= 1'b0;
    #1 chk(transfer_irq, 0, "irq masked");
    ss_n_in <= 1'b1;
    ss_is_input <= 1'b0;
    // Disabled port must not start on a data write
    wr(0, 8'h00);
    wr(2, 8'h5a);
    repeat (40) @(posedge ref_clk);
    rd(1, rd_v);
    chk(rd_v, 8'h01, "no start");
    stop_test;
end
endmodule // spi_master_slave_port_bench
`default_nettype wire
